// File: core/prb_pkg.sv
// constants, register map and state types for the root-port bridge
// assumes a 10 MHz core clock; link-side timing is sampled, not clocked
package prb_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned RST_DELAY_MS  = 100;
  localparam int unsigned RST_DELAY_CYC = RST_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned CTO_R0_US     = 50;
  localparam int unsigned CTO_R1_US     = 1000;
  localparam int unsigned CTO_R2_US     = 10000;
  localparam int unsigned CTO_R3_US     = 50000;
  localparam int unsigned CTO_R0_CYC    = CTO_R0_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CTO_R1_CYC    = CTO_R1_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CTO_R2_CYC    = CTO_R2_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CTO_R3_CYC    = CTO_R3_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W         = 24;

  localparam int unsigned NPORT = 3;
  localparam int unsigned NLANE = 5;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_POL    = 8'h04;
  localparam logic [7:0] OFS_CTO    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ERR    = 8'h10;

  localparam int unsigned CTRL_SPLIT  = 0;
  localparam int unsigned CTRL_REV    = 2;
  localparam int unsigned CTRL_WID    = 3;
  localparam int unsigned CTRL_GEN2   = 5;
  localparam int unsigned CTRL_EN     = 8;
  localparam int unsigned CTRL_SWRST  = 11;
  localparam int unsigned CTRL_CLKREQ = 14;
  localparam logic [16:0] CTRL_RESET  = 17'h00700;

  localparam int unsigned ST_LINKUP = 0;
  localparam int unsigned ST_WID    = 3;
  localparam int unsigned ST_GEN2   = 5;
  localparam int unsigned ST_WAKE   = 8;
  localparam int unsigned ST_CLKREQ = 9;
  localparam int unsigned ST_RST    = 12;
  localparam int unsigned ERR_DROP_UP = 3;
  localparam int unsigned ERR_DROP_DN = 4;

  localparam logic [1:0] SPLIT_X4X1   = 2'h0;
  localparam logic [1:0] SPLIT_X2X1X1 = 2'h1;
  localparam logic [1:0] WID_X4       = 2'h0;
  localparam logic [1:0] WID_X2       = 2'h1;
  localparam logic [1:0] WID_X1       = 2'h2;

  localparam logic [9:0] MAX_PAYLOAD_DW = 10'h020;
  localparam logic [7:0] TS_PATTERN     = 8'hBC;
  localparam logic [3:0] TRAIN_HITS     = 4'h8;
  localparam logic [3:0] RECOV_HITS     = 4'h4;

  typedef enum logic [2:0] {LNK_OFF, LNK_DETECT, LNK_TRAIN, LNK_UP, LNK_RECOV} prb_lnk_state_t;
endpackage : prb_pkg

// File: core/prb_root_port_bridge.sv
// root-port bridge: lane split, link bring-up, sideband pins, request paths
// assumes an APB master on i_clk and a link clock far slower than i_clk
// What this block does
// - five lanes shared by three ports in x4+x1, x2+x1+x1 or x1x3 splits
// - wide port runs four, two or one lanes
// - wide port reverses lanes at x4 and flips them at x2 or x1
// - wide port retrains to new width or speed while up
// - every link may run at second generation rate
// - narrow ports run one lane, either speed, with receive polarity inversion
// - each port owns reset, reference clock and clock request; wake is shared
// - payloads capped at 128 bytes; 64-bit addresses carried in headers
// - non-posted requests without completion flag a selectable timeout
// - packets with prefixes or digests are neither made nor accepted
// - requests stay in order; relaxed-ordering attribute passes along
// - no-snoop attribute of inbound requests is forwarded to the system side
// - id-based ordering attribute is ignored and normal order kept
// - all ports share one upstream and one downstream request path, tagged by port
// - a port's reference clock runs while its endpoint requests it
// - port resets held until 100 ms after slot power is stable
// - wide lanes 0 to 3 sit on fixed pins, two shared with others
`timescale 1ns/1ps
`default_nettype none
module prb_root_port_bridge
  import prb_pkg::*;
#(
  parameter int unsigned RST_DELAY_CYCLES = RST_DELAY_CYC,
  parameter int unsigned CTO_R1_CYCLES    = CTO_R1_CYC,
  parameter int unsigned CTO_R2_CYCLES    = CTO_R2_CYC,
  parameter int unsigned CTO_R3_CYCLES    = CTO_R3_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_slot_power_good,
  input  wire logic        i_link_clk,
  input  wire logic        i_wide_lane0_receive,
  input  wire logic        i_superspeed_shared_lane1_receive,
  input  wire logic        i_shared_lane2_receive,
  input  wire logic        i_spare_lane3_receive,
  input  wire logic        i_narrow_port_b_receive,
  input  wire logic        i_shared_link_wake_n,
  input  wire logic        i_wide_port_refclk_request_n,
  output logic             o_wide_port_refclk_request_n,
  output logic             o_wide_port_refclk_request_n_oe,
  input  wire logic        i_narrow_port_a_refclk_request_n,
  output logic             o_narrow_port_a_refclk_request_n,
  output logic             o_narrow_port_a_refclk_request_n_oe,
  input  wire logic        i_narrow_port_b_refclk_request_n,
  output logic             o_narrow_port_b_refclk_request_n,
  output logic             o_narrow_port_b_refclk_request_n_oe,
  output logic             o_wide_port_refclk_p,
  output logic             o_wide_port_refclk_n,
  output logic             o_narrow_port_a_refclk_p,
  output logic             o_narrow_port_a_refclk_n,
  output logic             o_narrow_port_b_refclk_p,
  output logic             o_narrow_port_b_refclk_n,
  output logic             o_wide_port_reset_n,
  output logic             o_narrow_port_a_reset_n,
  output logic             o_narrow_port_b_reset_n,
  output logic [31:0]      o_wide_rx_word,
  input  wire logic        i_rx_req_valid,
  output logic             o_rx_req_ready,
  input  wire logic [1:0]  i_rx_req_port,
  input  wire logic [63:0] i_rx_req_addr,
  input  wire logic [9:0]  i_rx_req_len_dw,
  input  wire logic        i_rx_req_write,
  input  wire logic        i_rx_req_prefix,
  input  wire logic        i_rx_req_digest,
  input  wire logic        i_rx_req_nosnoop,
  input  wire logic        i_rx_req_relaxed,
  output logic             o_axi_up_valid,
  input  wire logic        i_axi_up_ready,
  output logic [1:0]       o_axi_up_port,
  output logic [63:0]      o_axi_up_addr,
  output logic [9:0]       o_axi_up_len_dw,
  output logic             o_axi_up_write,
  output logic             o_axi_up_nosnoop,
  output logic             o_axi_up_relaxed,
  input  wire logic        i_axi_dn_valid,
  output logic             o_axi_dn_ready,
  input  wire logic [1:0]  i_axi_dn_port,
  input  wire logic [63:0] i_axi_dn_addr,
  input  wire logic [9:0]  i_axi_dn_len_dw,
  input  wire logic        i_axi_dn_nonposted,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic [1:0]       o_tx_port,
  output logic [63:0]      o_tx_addr,
  output logic [9:0]       o_tx_len_dw,
  output logic             o_tx_nonposted,
  output logic             o_tx_hdr_4dw,
  input  wire logic        i_cpl_valid,
  input  wire logic [1:0]  i_cpl_port
);

  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == OFS_CTRL) reg_sel = 3'h1;
    else if (a == OFS_POL) reg_sel = 3'h2;
    else if (a == OFS_CTO) reg_sel = 3'h3;
    else if (a == OFS_STATUS) reg_sel = 3'h4;
    else if (a == OFS_ERR) reg_sel = 3'h5;
    else reg_sel = 3'h0;
  endfunction : reg_sel

  // physical lane carrying wide logical lane i
  function automatic logic [2:0] wide_phys(input logic [1:0] i, input logic [1:0] wid,
                                           input logic rev);
    if (!rev) wide_phys = {1'b0, i};
    else if (wid == WID_X4) wide_phys = {1'b0, 2'h3 - i};
    else if (wid == WID_X2) wide_phys = {1'b0, i ^ 2'h1};
    else wide_phys = 3'h1;
  endfunction : wide_phys

  function automatic logic bad_len(input logic [9:0] len);
    bad_len = (len == 10'h000) || (len > MAX_PAYLOAD_DW);
  endfunction : bad_len

  logic [16:0]      ctrl_r;
  logic [4:0]       pol_r;
  logic [1:0]       cto_sel_r;
  logic [4:0]       err_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic [2:0]       sel;
  logic             wr;
  logic [31:0]      status;
  logic [4:0]       lane_s1, lane_s2;
  logic             lclk_s1, lclk_s2, lclk_s3, lrise;
  logic [2:0]       creq_s1, creq_s2, creq_n;
  logic             wake_s1, wake_s2, pg_s1, pg_s2;
  logic [CNT_W-1:0] pwr_cnt_r;
  logic             pwr_ok_r;
  logic [2:0]       prst_n_r;
  logic             tog_r;
  logic [2:0]       rclk_p_r, rclk_n_r;
  logic [7:0]       lane_sh [NLANE];
  logic [4:0]       lane_ok;
  logic [1:0]       wide_wid, wid_lim;
  logic             wide_ok;
  logic [2:0]       port_ok, port_go, link_up, cto_hit, cto_start;
  logic [2:0]       cur_cfg [NPORT];
  logic [2:0]       want_cfg [NPORT];
  logic [CNT_W-1:0] cto_lim;
  logic             up_stall, up_take, up_bad, dn_stall, dn_take, dn_bad;

  assign sel = reg_sel(i_paddr);
  assign wr  = i_ce && i_psel && i_penable && i_pwrite;
  assign o_pready  = i_ce;
  assign o_prdata  = prdata_r;
  assign o_pslverr = pslverr_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r    <= CTRL_RESET;
      pol_r     <= 5'h00;
      cto_sel_r <= 2'h0;
    end else if (wr) begin
      if (sel == 3'h1) ctrl_r <= i_pwdata[16:0];
      else if (sel == 3'h2) pol_r <= i_pwdata[4:0];
      else if (sel == 3'h3) cto_sel_r <= i_pwdata[1:0];
    end
  end

  // read data and error captured in the setup cycle so both come from flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (i_ce && i_psel && !i_penable) begin
      pslverr_r <= (sel == 3'h0);
      if (i_pwrite || sel == 3'h0) prdata_r <= 32'h0000_0000;
      else if (sel == 3'h1) prdata_r <= {15'h0000, ctrl_r};
      else if (sel == 3'h2) prdata_r <= {27'h0000000, pol_r};
      else if (sel == 3'h3) prdata_r <= {30'h00000000, cto_sel_r};
      else if (sel == 3'h4) prdata_r <= status;
      else prdata_r <= {27'h0000000, err_r};
    end
  end

  // set wins over the write-one-to-clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) err_r <= 5'h00;
    else if (i_ce) begin
      err_r <= (err_r & ~((wr && sel == 3'h5) ? i_pwdata[4:0] : 5'h00))
             | {dn_take && dn_bad, up_take && up_bad, cto_hit};
    end
  end

  // wake only reaches the status word
  always_comb begin
    status = 32'h0000_0000;
    status[ST_LINKUP +: 3] = link_up;
    status[ST_WID +: 2]    = cur_cfg[0][2:1];
    status[ST_GEN2 +: 3]   = {cur_cfg[2][0], cur_cfg[1][0], cur_cfg[0][0]};
    status[ST_WAKE]        = !wake_s2;
    status[ST_CLKREQ +: 3] = ~creq_s2;
    status[ST_RST +: 3]    = ~prst_n_r;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lane_s1 <= 5'h00;
      lane_s2 <= 5'h00;
      {lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
      creq_s1 <= 3'h7;
      creq_s2 <= 3'h7;
      {wake_s1, wake_s2} <= 2'h3;
      {pg_s1, pg_s2} <= 2'h0;
    end else if (i_ce) begin
      lane_s1 <= {i_narrow_port_b_receive, i_spare_lane3_receive, i_shared_lane2_receive,
                  i_superspeed_shared_lane1_receive, i_wide_lane0_receive};
      lane_s2 <= lane_s1;
      {lclk_s1, lclk_s2, lclk_s3} <= {i_link_clk, lclk_s1, lclk_s2};
      creq_s1 <= {i_narrow_port_b_refclk_request_n, i_narrow_port_a_refclk_request_n,
                  i_wide_port_refclk_request_n};
      creq_s2 <= creq_s1;
      {wake_s1, wake_s2} <= {i_shared_link_wake_n, wake_s1};
      {pg_s1, pg_s2} <= {i_slot_power_good, pg_s1};
    end
  end
  assign lrise = lclk_s2 && !lclk_s3;

  // release resets a fixed delay after slot power settles
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_cnt_r <= '0;
      pwr_ok_r  <= 1'b0;
      prst_n_r  <= 3'h0;
    end else if (i_ce) begin
      if (!pg_s2) begin
        pwr_cnt_r <= '0;
        pwr_ok_r  <= 1'b0;
      end else if (pwr_cnt_r == CNT_W'(RST_DELAY_CYCLES - 1)) pwr_ok_r <= 1'b1;
      else pwr_cnt_r <= pwr_cnt_r + 1'b1;
      prst_n_r <= {3{pwr_ok_r}} & ~ctrl_r[CTRL_SWRST +: 3];
    end
  end
  assign {o_narrow_port_b_reset_n, o_narrow_port_a_reset_n, o_wide_port_reset_n} = prst_n_r;

  // reference clock per port follows its clock request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tog_r    <= 1'b0;
      rclk_p_r <= 3'h0;
      rclk_n_r <= 3'h0;
    end else if (i_ce) begin
      tog_r    <= !tog_r;
      rclk_p_r <= ~creq_s2 & {3{tog_r}};
      rclk_n_r <= ~creq_s2 & {3{!tog_r}};
    end
  end
  assign {o_narrow_port_b_refclk_p, o_narrow_port_a_refclk_p, o_wide_port_refclk_p} = rclk_p_r;
  assign {o_narrow_port_b_refclk_n, o_narrow_port_a_refclk_n, o_wide_port_refclk_n} = rclk_n_r;
  // the device only ever pulls a request low; forcing it keeps the clock on
  assign creq_n = 3'h0;
  assign {o_narrow_port_b_refclk_request_n, o_narrow_port_a_refclk_request_n,
          o_wide_port_refclk_request_n} = creq_n;
  assign {o_narrow_port_b_refclk_request_n_oe, o_narrow_port_a_refclk_request_n_oe,
          o_wide_port_refclk_request_n_oe} = ctrl_r[CTRL_CLKREQ +: 3];

  // per-lane polarity inversion ahead of symbol detection
  for (genvar l = 0; l < NLANE; l++) begin : g_lane
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) lane_sh[l] <= 8'h00;
      else if (i_ce && lrise) lane_sh[l] <= {lane_sh[l][6:0], lane_s2[l] ^ pol_r[l]};
    end
    assign lane_ok[l] = (lane_sh[l] == TS_PATTERN);
  end

  // split bounds the wide width; narrower requests honoured
  assign wid_lim  = (ctrl_r[CTRL_SPLIT +: 2] == SPLIT_X4X1) ? WID_X4 :
                    (ctrl_r[CTRL_SPLIT +: 2] == SPLIT_X2X1X1) ? WID_X2 : WID_X1;
  assign wide_wid = (ctrl_r[CTRL_WID +: 2] > wid_lim) ? WID_X1 >= ctrl_r[CTRL_WID +: 2] ?
                    ctrl_r[CTRL_WID +: 2] : WID_X1 : wid_lim;

  // wide logical lanes land on fixed pins 0 to 3; reordering
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) o_wide_rx_word <= 32'h0000_0000;
    else if (i_ce && lrise) begin
      for (int i = 0; i < 4; i++) begin
        if (i < (4 >> wide_wid))
          o_wide_rx_word[8*i +: 8] <= lane_sh[wide_phys(2'(i), wide_wid, ctrl_r[CTRL_REV])];
        else
          o_wide_rx_word[8*i +: 8] <= 8'h00;
      end
    end
  end

  always_comb begin
    wide_ok = 1'b1;
    for (int i = 0; i < 4; i++)
      if (i < (4 >> wide_wid)) wide_ok &= lane_ok[wide_phys(2'(i), wide_wid, ctrl_r[CTRL_REV])];
  end

  assign port_ok     = {lane_ok[4], lane_ok[2], wide_ok};
  assign port_go     = ctrl_r[CTRL_EN +: 3] & prst_n_r
                       & {1'b1, ctrl_r[CTRL_SPLIT +: 2] != SPLIT_X4X1, 1'b1};
  // second generation rate requested per port
  assign want_cfg[0] = {wide_wid, ctrl_r[CTRL_GEN2]};
  assign want_cfg[1] = {WID_X1, ctrl_r[CTRL_GEN2 + 1]};
  assign want_cfg[2] = {WID_X1, ctrl_r[CTRL_GEN2 + 2]};

  // one independent bring-up machine per port
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    prb_lnk_state_t st_r;
    logic [3:0]     hit_r;
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        st_r       <= LNK_OFF;
        hit_r      <= 4'h0;
        cur_cfg[p] <= {WID_X1, 1'b0};
      end else if (i_ce) begin
        if (!port_go[p]) st_r <= LNK_OFF;
        else if (lrise) begin
          case (st_r)
            LNK_OFF: st_r <= LNK_DETECT;
            LNK_DETECT: begin
              hit_r <= 4'h0;
              if (port_ok[p]) st_r <= LNK_TRAIN;
            end
            LNK_TRAIN: begin
              if (!port_ok[p]) st_r <= LNK_DETECT;
              else if (hit_r == TRAIN_HITS - 4'h1) begin
                st_r       <= LNK_UP;
                cur_cfg[p] <= want_cfg[p];
              end else hit_r <= hit_r + 4'h1;
            end
            // width or speed change retrains without dropping the link
            LNK_UP: begin
              hit_r <= 4'h0;
              if (want_cfg[p] != cur_cfg[p]) st_r <= LNK_RECOV;
            end
            LNK_RECOV: begin
              if (!port_ok[p]) hit_r <= 4'h0;
              else if (hit_r == RECOV_HITS - 4'h1) begin
                st_r       <= LNK_UP;
                cur_cfg[p] <= want_cfg[p];
              end else hit_r <= hit_r + 4'h1;
            end
            default: st_r <= LNK_OFF;
          endcase
        end
      end
    end
    assign link_up[p] = (st_r == LNK_UP);

    // one timer per port restarts on every non-posted request sent to that port
    logic             cto_run_r;
    logic [CNT_W-1:0] cto_cnt_r;
    assign cto_hit[p] = cto_run_r && (cto_cnt_r == cto_lim - 1'b1);
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        cto_run_r <= 1'b0;
        cto_cnt_r <= '0;
      end else if (i_ce) begin
        if (cto_start[p]) begin
          cto_run_r <= 1'b1;
          cto_cnt_r <= '0;
        end else if ((i_cpl_valid && i_cpl_port == 2'(p)) || cto_hit[p]) cto_run_r <= 1'b0;
        else if (cto_run_r) cto_cnt_r <= cto_cnt_r + 1'b1;
      end
    end
    assign cto_start[p] = dn_take && !dn_bad && i_axi_dn_nonposted && i_axi_dn_port == 2'(p);

    a_link_needs_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
      link_up[p] |-> prst_n_r[p]) else $error("link up while port reset held");
    a_cto_flags_err: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && cto_hit[p]) |=> err_r[p]) else $error("timeout not flagged");
  end

  assign cto_lim = (cto_sel_r == 2'h0) ? CNT_W'(CTO_R0_CYC) :
                   (cto_sel_r == 2'h1) ? CNT_W'(CTO_R1_CYCLES) :
                   (cto_sel_r == 2'h2) ? CNT_W'(CTO_R2_CYCLES) : CNT_W'(CTO_R3_CYCLES);

  // upstream path; prefixed, digested or oversize packets dropped
  assign up_bad   = bad_len(i_rx_req_len_dw) || i_rx_req_prefix || i_rx_req_digest
                    || i_rx_req_port == 2'h3;
  assign up_stall = o_axi_up_valid && !i_axi_up_ready;
  assign o_rx_req_ready = i_ce && !up_stall;
  assign up_take  = i_rx_req_valid && o_rx_req_ready;
  // single in-order stage; no-snoop forwarded; no id order
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_axi_up_valid <= 1'b0;
      {o_axi_up_port, o_axi_up_addr, o_axi_up_len_dw} <= '0;
      {o_axi_up_write, o_axi_up_nosnoop, o_axi_up_relaxed} <= 3'h0;
    end else if (i_ce) begin
      if (i_axi_up_ready) o_axi_up_valid <= 1'b0;
      if (up_take && !up_bad) begin
        o_axi_up_valid   <= 1'b1;
        o_axi_up_port    <= i_rx_req_port;
        o_axi_up_addr    <= i_rx_req_addr;
        o_axi_up_len_dw  <= i_rx_req_len_dw;
        o_axi_up_write   <= i_rx_req_write;
        o_axi_up_nosnoop <= i_rx_req_nosnoop;
        o_axi_up_relaxed <= i_rx_req_relaxed;
      end
    end
  end

  // downstream headers go four-dword when the upper address is used
  assign dn_bad   = bad_len(i_axi_dn_len_dw) || i_axi_dn_port == 2'h3;
  assign dn_stall = o_tx_valid && !i_tx_ready;
  assign o_axi_dn_ready = i_ce && !dn_stall;
  assign dn_take  = i_axi_dn_valid && o_axi_dn_ready;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tx_valid <= 1'b0;
      {o_tx_port, o_tx_addr, o_tx_len_dw, o_tx_nonposted, o_tx_hdr_4dw} <= '0;
    end else if (i_ce) begin
      if (i_tx_ready) o_tx_valid <= 1'b0;
      if (dn_take && !dn_bad) begin
        o_tx_valid     <= 1'b1;
        o_tx_port      <= i_axi_dn_port;
        o_tx_addr      <= i_axi_dn_addr;
        o_tx_len_dw    <= i_axi_dn_len_dw;
        o_tx_nonposted <= i_axi_dn_nonposted;
        o_tx_hdr_4dw   <= |i_axi_dn_addr[63:32];
      end
    end
  end

  a_reset_until_power: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !pg_s2 |=> ##1 (prst_n_r == 3'h0)) else $error("port reset released early");
  a_refclk_gated: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && creq_s2[0]) |=> !o_wide_port_refclk_p && !o_wide_port_refclk_n)
    else $error("refclk running without request");
  a_refclk_toggles: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !creq_s2[0]) [*2] |=> (o_wide_port_refclk_p != o_wide_port_refclk_n))
    else $error("refclk pair not complementary");
  a_oversize_dropped: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (up_take && up_bad && !o_axi_up_valid) |=> !o_axi_up_valid && err_r[ERR_DROP_UP])
    else $error("bad upstream packet passed");
  a_nosnoop_fwd: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (up_take && !up_bad) |=> o_axi_up_valid && o_axi_up_nosnoop == $past(i_rx_req_nosnoop))
    else $error("no-snoop not forwarded");
  a_hdr_addr64: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (dn_take && !dn_bad) |=> o_tx_hdr_4dw == (o_tx_addr[63:32] != 32'h0000_0000))
    else $error("header format wrong for address");
  a_split_width: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ctrl_r[CTRL_SPLIT +: 2] != SPLIT_X4X1) |-> (wide_wid != WID_X4))
    else $error("wide port wider than split allows");
  // the narrow port sharing lane 2 must drop one edge after the x4 split is chosen
  a_split_narrow: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && ctrl_r[CTRL_SPLIT +: 2] == SPLIT_X4X1) |=> !link_up[1])
    else $error("shared lane used by two ports");
endmodule : prb_root_port_bridge
`default_nettype wire

// File: test/prb_ep_model.sv
// endpoint stand-in: free-running link clock, training lanes, clock request
// assumes every lane input of the bridge is fed from o_lane
`timescale 1ns/1ps
`default_nettype none
module prb_ep_model (
  output logic o_link_clk,
  output logic o_lane,
  output logic o_clkreq_n
);
  logic [7:0] pat_r;
  initial begin
    o_link_clk = 1'b0;
    o_lane     = 1'b0;
    o_clkreq_n = 1'b1;
    pat_r      = 8'hBC;
    #30000;
    o_clkreq_n = 1'b0;
    // training pattern, changed away from the sampling edge
    forever begin
      #400 o_link_clk = ~o_link_clk;
      if (!o_link_clk) begin
        o_lane = pat_r[7];
        pat_r  = {pat_r[6:0], pat_r[7]};
      end
    end
  end
endmodule : prb_ep_model
`default_nettype wire

// File: test/test_prb_root_port_bridge.sv
// bench: apb access, request paths and sideband pins of the bridge
// assumes prb_ep_model supplies link clock, lanes and clock requests
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_prb_root_port_bridge;
  import prb_pkg::*;
  localparam logic [63:0] A = 64'h1_0000_0040;
  int bad_count = 0, checked = 0;
  logic i_clk = 0, i_nrst = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, s, p;
  logic [7:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, r, o_wide_rx_word;
  logic o_pready, o_pslverr, i_slot_power_good = 0, i_link_clk, lane, req_n;
  logic i_shared_link_wake_n = 1, i_rx_req_valid = 0, i_rx_req_write = 1, i_rx_req_prefix = 0;
  logic i_rx_req_digest = 0, i_rx_req_nosnoop = 1, i_rx_req_relaxed = 1, i_axi_up_ready = 1;
  logic i_axi_dn_valid = 0, i_axi_dn_nonposted = 1, i_tx_ready = 1, i_cpl_valid = 0;
  logic [1:0] i_rx_req_port = 2'h1, i_axi_dn_port = 2'h0, i_cpl_port = 2'h0, o_axi_up_port, o_tx_port;
  logic [63:0] i_rx_req_addr = A, i_axi_dn_addr = A, o_axi_up_addr, o_tx_addr;
  logic [9:0] i_rx_req_len_dw = '0, i_axi_dn_len_dw = 10'h001, o_axi_up_len_dw, o_tx_len_dw;
  logic o_rx_req_ready, o_axi_up_valid, o_axi_up_write, o_axi_up_nosnoop, o_axi_up_relaxed;
  logic o_axi_dn_ready, o_tx_valid, o_tx_nonposted, o_tx_hdr_4dw;
  logic o_wide_port_refclk_request_n, o_wide_port_refclk_request_n_oe, o_wide_port_refclk_p;
  logic o_narrow_port_a_refclk_request_n, o_narrow_port_a_refclk_request_n_oe;
  logic o_narrow_port_b_refclk_request_n, o_narrow_port_b_refclk_request_n_oe;
  logic o_wide_port_refclk_n, o_narrow_port_a_refclk_p, o_narrow_port_a_refclk_n;
  logic o_narrow_port_b_refclk_p, o_narrow_port_b_refclk_n;
  logic o_wide_port_reset_n, o_narrow_port_a_reset_n, o_narrow_port_b_reset_n;
  wire i_wide_lane0_receive = lane, i_superspeed_shared_lane1_receive = lane;
  wire i_shared_lane2_receive = lane, i_spare_lane3_receive = lane, i_narrow_port_b_receive = lane;
  // open-drain request wires: low if either side pulls
  wire i_wide_port_refclk_request_n = req_n &
    ~(o_wide_port_refclk_request_n_oe & ~o_wide_port_refclk_request_n);
  wire i_narrow_port_a_refclk_request_n = req_n &
    ~(o_narrow_port_a_refclk_request_n_oe & ~o_narrow_port_a_refclk_request_n);
  wire i_narrow_port_b_refclk_request_n = req_n &
    ~(o_narrow_port_b_refclk_request_n_oe & ~o_narrow_port_b_refclk_request_n);
  prb_root_port_bridge #(.RST_DELAY_CYCLES(20), .CTO_R1_CYCLES(40), .CTO_R2_CYCLES(60),
    .CTO_R3_CYCLES(80)) uut (.*);
  prb_ep_model ep (.o_link_clk(i_link_clk), .o_lane(lane), .o_clkreq_n(req_n));
  initial forever #50 i_clk = ~i_clk;
  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk) i_penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (n == 20) begin bad_count++; conclude(); end
    r = o_prdata; s = o_pslverr;
    i_psel <= 0; i_penable <= 0;
    @(posedge i_clk);
  endtask : apb
  task automatic req(input logic dn, input logic [9:0] len, input logic pre, input logic dig);
    int n;
    i_rx_req_valid <= !dn; i_axi_dn_valid <= dn;
    i_rx_req_len_dw <= len; i_rx_req_prefix <= pre; i_rx_req_digest <= dig;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if ((dn ? o_axi_dn_ready : o_rx_req_ready) === 1'b1) break;
    end
    if (n == 20) begin bad_count++; conclude(); end
    i_rx_req_valid <= 0; i_axi_dn_valid <= 0;
    #1;
  endtask : req
  initial begin
    #5_000_000 bad_count++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_nrst <= 1;
    @(posedge i_clk) i_slot_power_good <= 1;
    apb(0, OFS_CTRL, 0);
    `CHK(r, 32'h00000700)
    apb(0, 8'h20, 0);
    `CHK({s, r}, 33'h100000000)
    repeat (12) @(posedge i_clk);
    `CHK({o_wide_port_reset_n, o_narrow_port_a_reset_n, o_narrow_port_b_reset_n}, 3'h0)
    repeat (8) @(posedge i_clk);
    `CHK({o_wide_port_reset_n, o_narrow_port_a_reset_n, o_narrow_port_b_reset_n}, 3'h7)
    req(0, MAX_PAYLOAD_DW, 0, 0);
    `CHK({o_axi_up_valid, o_axi_up_nosnoop, o_axi_up_relaxed, o_axi_up_write}, 4'hF)
    `CHK({o_axi_up_addr, o_axi_up_len_dw, o_axi_up_port}, {A, MAX_PAYLOAD_DW, 2'h1})
    @(posedge i_clk) req(0, 10'h021, 0, 0);
    `CHK(o_axi_up_valid, 1'b0)
    @(posedge i_clk) req(0, 10'h001, 1, 0);
    `CHK(o_axi_up_valid, 1'b0)
    @(posedge i_clk) req(0, 10'h001, 0, 1);
    `CHK(o_axi_up_valid, 1'b0)
    @(posedge i_clk) apb(0, OFS_ERR, 0);
    `CHK(r[4:0], 5'h08)
    apb(1, OFS_CTO, 32'h1);
    req(1, 10'h001, 0, 0);
    `CHK({o_tx_valid, o_tx_hdr_4dw, o_tx_nonposted, o_tx_addr}, {3'h7, A})
    repeat (60) @(posedge i_clk);
    apb(0, OFS_ERR, 0);
    `CHK(r[0], 1'b1)
    apb(1, OFS_ERR, 32'h1F);
    req(1, 10'h001, 0, 0);
    @(posedge i_clk) i_cpl_valid <= 1;
    @(posedge i_clk) i_cpl_valid <= 0;
    repeat (60) @(posedge i_clk);
    apb(0, OFS_ERR, 0);
    `CHK(r[0], 1'b0)
    repeat (200) @(posedge i_clk);
    #1 p = o_wide_port_refclk_p;
    @(posedge i_clk) #1;
    `CHK({o_wide_port_refclk_p, o_wide_port_refclk_n}, {~p, p})
    `CHK({o_narrow_port_a_refclk_p ^ o_narrow_port_a_refclk_n,
      o_narrow_port_b_refclk_p ^ o_narrow_port_b_refclk_n}, 2'h3)
    @(posedge i_clk) i_shared_link_wake_n <= 0;
    repeat (3) @(posedge i_clk);
    apb(0, OFS_STATUS, 0);
    `CHK({r[ST_WAKE], o_wide_port_reset_n, o_narrow_port_a_reset_n}, 3'h7)
    conclude();
  end
endmodule : test_prb_root_port_bridge
`default_nettype wire
